/* File: pkg/pcr_cfg.svh */
`ifndef PCR_CFG_SVH
`define PCR_CFG_SVH

// ****************************************************************
// register map
// ****************************************************************
`define PCR_ADDR_W 8
`define PCR_ADDR_CFG 8'hAA
`define PCR_ADDR_STAT 8'hAB
`define PCR_ADDR_MASK 8'hAC
`define PCR_CFG_RESET 32'h00000000
`define PCR_CFG_WMASK 32'hDFFFFFE0

// ****************************************************************
// configuration field positions
// ****************************************************************
`define PCR_B_PARITY 31
`define PCR_B_DITHER_OFF 30
`define PCR_B_NOMTR_OFF 28
`define PCR_F_BEMF_LSB 26
`define PCR_F_FLUX_LSB 24
`define PCR_F_WIN_LSB 22
`define PCR_B_PWR_LIM 21
`define PCR_F_DIR_LSB 19
`define PCR_B_DIR_MODE 18
`define PCR_B_SPD_LIM 17

// ****************************************************************
// status and mask bit positions
// ****************************************************************
`define PCR_STAT_W 4
`define PCR_STAT_RESET 4'h0
`define PCR_S_BEMF 0
`define PCR_S_NOMTR 1
`define PCR_S_DIRCHG 2
`define PCR_S_LOOPOFF 3

// ****************************************************************
// field codes and percentages
// ****************************************************************
`define PCR_MODE_SPEED 2'h0
`define PCR_MODE_POWER 2'h1
`define PCR_LOCK2_ON 1'h1
`define PCR_FLUX_P0 7'h46
`define PCR_FLUX_P1 7'h50
`define PCR_FLUX_P2 7'h5A
`define PCR_FLUX_P3 7'h5F
`define PCR_WIN_P1 7'h05
`define PCR_WIN_P2 7'h0A
`define PCR_WIN_P3 7'h0F
`define PCR_PCT_FULL 32'h00000064

// ****************************************************************
// timing
// ****************************************************************
`define PCR_CLK_PERIOD_PS 4000
`define PCR_MS_PS 1000000000
`define PCR_BEMF_ECYC 2
`define PCR_BEMF_T1_MS 500
`define PCR_BEMF_T2_MS 1000
`define PCR_BEMF_T3_MS 2000

`endif

/* File: pkg/pcr_pkg.sv */
`default_nettype none

package pcr_pkg;

  // direction override codes
  typedef enum logic [1:0] {
    PCR_DIR_PIN = 2'h0,
    PCR_DIR_CW = 2'h1,
    PCR_DIR_CCW = 2'h2,
    PCR_DIR_PIN_ALT = 2'h3
  } pcr_dir_sel_t;

  // back-emf deglitch states, one-hot
  typedef enum logic [2:0] {
    PCR_DG_IDLE = 3'h1,
    PCR_DG_TIMING = 3'h2,
    PCR_DG_FAULT = 3'h4
  } pcr_dg_state_t;

endpackage

`default_nettype wire

/* File: pkg/pcr_cap_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// value, ceiling and result of one limiter
// ****************************************************************
interface pcr_cap_if #(parameter int W = 16);
  logic [W-1:0] value;
  logic [W-1:0] limit;
  logic en;
  logic [W-1:0] cmd;
  logic capped;

  modport src (output value, output limit, output en, input cmd, input capped);
  modport lim (input value, input limit, input en, output cmd, output capped);
endinterface

`default_nettype wire

/* File: rtl/pcr_limiter.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// registered ceiling on one command value
// ****************************************************************
module pcr_limiter #(
  parameter int W = 16
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  pcr_cap_if.lim cap
);

  logic [W-1:0] cmd_q;
  logic [W-1:0] cmd_d;
  logic capped_q;
  logic capped_d;

  // clamp when enabled and above the ceiling
  always_comb
  begin
    capped_d = cap.en && (cap.value > cap.limit);
    cmd_d = capped_d ? cap.limit : cap.value;
  end

  // result registers
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cmd_q <= '0;
      capped_q <= 1'b0;
    end
    else
    begin
      cmd_q <= cmd_d;
      capped_q <= capped_d;
    end
  end

  assign cap.cmd = cmd_q;
  assign cap.capped = capped_q;

endmodule

`default_nettype wire

/* File: rtl/pcr_deglitch.sv */
`timescale 1ns/1ps
`default_nettype none

`include "pcr_cfg.svh"

// ****************************************************************
// abnormal back-emf persistence timer
// ****************************************************************
module pcr_deglitch #(
  parameter int MS_CYCLES = `PCR_MS_PS / `PCR_CLK_PERIOD_PS,
  parameter int PW = $clog2(MS_CYCLES + 1)
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic abnormal_i,
  input wire logic elec_cycle_i,
  input wire logic [1:0] sel_i,
  output logic fault_o
);

  pcr_pkg::pcr_dg_state_t state_q;
  pcr_pkg::pcr_dg_state_t state_d;
  logic [PW-1:0] pre_q;
  logic [PW-1:0] pre_d;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic fault_q;
  logic fault_d;
  logic [11:0] target;
  logic ms_tick;
  logic tick;

  // persistence target and timing tick per code
  always_comb
  begin
    case (sel_i)
      2'h0: target = 12'(`PCR_BEMF_ECYC);
      2'h1: target = 12'(`PCR_BEMF_T1_MS);
      2'h2: target = 12'(`PCR_BEMF_T2_MS);
      default: target = 12'(`PCR_BEMF_T3_MS);
    endcase
    ms_tick = (pre_q == PW'(MS_CYCLES - 1));
    tick = (sel_i == 2'h0) ? elec_cycle_i : ms_tick;
  end

  // next state: fault once the condition outlasts the target
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    fault_d = fault_q;
    pre_d = (ms_tick || state_q != pcr_pkg::PCR_DG_TIMING) ? '0 : pre_q + PW'(1);
    case (state_q)
      pcr_pkg::PCR_DG_IDLE:
      begin
        cnt_d = '0;
        if (abnormal_i)
          state_d = pcr_pkg::PCR_DG_TIMING;
      end
      pcr_pkg::PCR_DG_TIMING:
      begin
        if (!abnormal_i)
          state_d = pcr_pkg::PCR_DG_IDLE;
        else if (tick && (cnt_q + 12'h001 >= target))
        begin
          state_d = pcr_pkg::PCR_DG_FAULT;
          fault_d = 1'b1;
        end
        else if (tick)
          cnt_d = cnt_q + 12'h001;
      end
      pcr_pkg::PCR_DG_FAULT:
      begin
        if (!abnormal_i)
        begin
          state_d = pcr_pkg::PCR_DG_IDLE;
          fault_d = 1'b0;
        end
      end
      default:
      begin
        state_d = pcr_pkg::PCR_DG_IDLE;
        fault_d = 1'b0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q <= pcr_pkg::PCR_DG_IDLE;
      pre_q <= '0;
      cnt_q <= '0;
      fault_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      fault_q <= fault_d;
    end
  end

  assign fault_o = fault_q;

endmodule

`default_nettype wire

/* File: rtl/pcr_top.sv */
// What this block does
// - config register at AAh, resets to zero
// - bit 30 high turns clock dithering off
// - closed-loop absent-motor fault needs lock2, bit28 low
// - bits 27-26 pick back-emf fault persistence
// - bits 25-24 pick flux weakening reference
// - bits 23-22 window; inside it loops stop
// - bit 21 caps bus power except power mode
// - bits 20-19 pin, clockwise or counter-clockwise
// - bit 18 picks direction-change response
// - zero: stop then spin detect; one: reverse drive
// - bit 17 caps speed except speed mode
`timescale 1ns/1ps
`default_nettype none

`include "pcr_cfg.svh"

module pcr_top #(
  parameter int W = 16,
  parameter int MS_CYCLES = `PCR_MS_PS / `PCR_CLK_PERIOD_PS
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [`PCR_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic dir_pin_i,
  input wire logic second_lock_detect_enable_i,
  input wire logic closed_loop_i,
  input wire logic no_motor_detect_i,
  input wire logic bemf_abnormal_i,
  input wire logic elec_cycle_i,
  input wire logic [1:0] input_ref_mode_i,
  input wire logic [W-1:0] bus_power_i,
  input wire logic [W-1:0] max_power_i,
  input wire logic [W-1:0] speed_ref_i,
  input wire logic [W-1:0] max_speed_i,
  input wire logic [W-1:0] ctrl_output_i,
  input wire logic [W-1:0] ctrl_reference_i,
  output logic spread_clock_modulation_o,
  output logic absent_motor_fault_o,
  output logic backemf_fault_o,
  output logic [6:0] flux_weak_ref_o,
  output logic loops_off_o,
  output logic [W-1:0] power_cmd_o,
  output logic power_capped_o,
  output logic [W-1:0] speed_cmd_o,
  output logic speed_capped_o,
  output logic phase_order_ccw_o,
  output logic dir_stop_isd_o,
  output logic dir_reverse_drive_o,
  output logic irq_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic [`PCR_STAT_W-1:0] stat_q;
  logic [`PCR_STAT_W-1:0] stat_d;
  logic [`PCR_STAT_W-1:0] mask_q;
  logic [`PCR_STAT_W-1:0] mask_d;
  logic [`PCR_STAT_W-1:0] evt;
  logic [`PCR_STAT_W-1:0] w1c;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic ssm_q;
  logic ssm_d;
  logic nomtr_q;
  logic nomtr_d;
  logic [6:0] flux_q;
  logic [6:0] flux_d;
  logic loops_off_q;
  logic loops_off_d;
  logic ccw_q;
  logic ccw_d;
  logic dir_pin_q;
  logic dir_stop_q;
  logic dir_stop_d;
  logic dir_rev_q;
  logic dir_rev_d;
  logic bemf_fault;
  logic bemf_fault_q;
  logic pin_followed;
  logic dir_change;
  logic [6:0] win_pct;
  logic [W-1:0] err_mag;
  logic [31:0] err_scaled;
  logic [31:0] win_span;
  pcr_pkg::pcr_dir_sel_t dir_sel;

  pcr_cap_if #(.W(W)) pwr_cap ();
  pcr_cap_if #(.W(W)) spd_cap ();

  // ****************************************************************
  // register bus
  // ****************************************************************

  // configuration, status and mask next values
  always_comb
  begin
    cfg_d = cfg_q;
    mask_d = mask_q;
    w1c = '0;
    if (reg_wr_i && reg_addr_i == `PCR_ADDR_CFG)
      cfg_d = reg_wdata_i & `PCR_CFG_WMASK;
    if (reg_wr_i && reg_addr_i == `PCR_ADDR_MASK)
      mask_d = reg_wdata_i[`PCR_STAT_W-1:0];
    if (reg_wr_i && reg_addr_i == `PCR_ADDR_STAT)
      w1c = reg_wdata_i[`PCR_STAT_W-1:0];
    // a new event wins over a clear in the same cycle
    stat_d = (stat_q & ~w1c) | evt;
  end

  // read data for the cycle after the strobe only
  always_comb
  begin
    rdata_d = '0;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `PCR_ADDR_CFG: rdata_d = cfg_q;
        `PCR_ADDR_STAT: rdata_d = {{(32-`PCR_STAT_W){1'b0}}, stat_q};
        `PCR_ADDR_MASK: rdata_d = {{(32-`PCR_STAT_W){1'b0}}, mask_q};
        default: rdata_d = '0;
      endcase
    end
  end

  // interrupt level from unmasked sticky bits
  always_comb
  begin
    irq_d = |(stat_d & mask_d);
  end

  // register bank flops
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg_q <= `PCR_CFG_RESET;
      stat_q <= `PCR_STAT_RESET;
      mask_q <= `PCR_STAT_RESET;
      rdata_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  // ****************************************************************
  // clock dithering and fault gating
  // ****************************************************************

  // dithering active while the disable bit is low
  always_comb
  begin
    ssm_d = ~cfg_q[`PCR_B_DITHER_OFF];
  end

  // closed-loop absent-motor fault qualification
  always_comb
  begin
    nomtr_d = closed_loop_i && no_motor_detect_i
      && (second_lock_detect_enable_i == `PCR_LOCK2_ON)
      && !cfg_q[`PCR_B_NOMTR_OFF];
  end

  // back-emf persistence timer
  pcr_deglitch #(
    .MS_CYCLES(MS_CYCLES)
  ) u_deglitch (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .abnormal_i(bemf_abnormal_i),
    .elec_cycle_i(elec_cycle_i),
    .sel_i(cfg_q[`PCR_F_BEMF_LSB+:2]),
    .fault_o(bemf_fault)
  );

  // ****************************************************************
  // flux weakening and reference window
  // ****************************************************************

  // flux weakening reference percentage
  always_comb
  begin
    case (cfg_q[`PCR_F_FLUX_LSB+:2])
      2'h0: flux_d = `PCR_FLUX_P0;
      2'h1: flux_d = `PCR_FLUX_P1;
      2'h2: flux_d = `PCR_FLUX_P2;
      default: flux_d = `PCR_FLUX_P3;
    endcase
  end

  // window width in percent, zero means off
  always_comb
  begin
    case (cfg_q[`PCR_F_WIN_LSB+:2])
      2'h1: win_pct = `PCR_WIN_P1;
      2'h2: win_pct = `PCR_WIN_P2;
      2'h3: win_pct = `PCR_WIN_P3;
      default: win_pct = 7'h00;
    endcase
  end

  // loops off once output is within the window
  always_comb
  begin
    if (ctrl_output_i > ctrl_reference_i)
      err_mag = ctrl_output_i - ctrl_reference_i;
    else
      err_mag = ctrl_reference_i - ctrl_output_i;
    err_scaled = 32'(err_mag) * `PCR_PCT_FULL;
    win_span = 32'(ctrl_reference_i) * 32'(win_pct);
    loops_off_d = (win_pct != 7'h00) && (err_scaled <= win_span);
  end

  // ****************************************************************
  // power and speed ceilings
  // ****************************************************************

  // bus power ceiling outside power mode
  assign pwr_cap.value = bus_power_i;
  assign pwr_cap.limit = max_power_i;
  assign pwr_cap.en = cfg_q[`PCR_B_PWR_LIM]
    && (input_ref_mode_i != `PCR_MODE_POWER);

  // speed ceiling outside speed mode
  assign spd_cap.value = speed_ref_i;
  assign spd_cap.limit = max_speed_i;
  assign spd_cap.en = cfg_q[`PCR_B_SPD_LIM]
    && (input_ref_mode_i != `PCR_MODE_SPEED);

  pcr_limiter #(
    .W(W)
  ) u_pwr_lim (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .cap(pwr_cap)
  );

  pcr_limiter #(
    .W(W)
  ) u_spd_lim (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .cap(spd_cap)
  );

  // ****************************************************************
  // rotation direction
  // ****************************************************************

  // resolve phase order from override or pin
  always_comb
  begin
    dir_sel = pcr_pkg::pcr_dir_sel_t'(cfg_q[`PCR_F_DIR_LSB+:2]);
    pin_followed = 1'b0;
    case (dir_sel)
      pcr_pkg::PCR_DIR_CW: ccw_d = 1'b0;
      pcr_pkg::PCR_DIR_CCW: ccw_d = 1'b1;
      default:
      begin
        ccw_d = dir_pin_i;
        pin_followed = 1'b1;
      end
    endcase
  end

  // direction pin change picks stop or reverse drive
  always_comb
  begin
    dir_change = pin_followed && (dir_pin_i != dir_pin_q);
    dir_stop_d = dir_change && !cfg_q[`PCR_B_DIR_MODE];
    dir_rev_d = dir_change && cfg_q[`PCR_B_DIR_MODE];
  end

  // ****************************************************************
  // events
  // ****************************************************************

  // rising fault edges, direction change, loop stop entry
  always_comb
  begin
    evt = '0;
    evt[`PCR_S_BEMF] = bemf_fault && !bemf_fault_q;
    evt[`PCR_S_NOMTR] = nomtr_d && !nomtr_q;
    evt[`PCR_S_DIRCHG] = dir_change;
    evt[`PCR_S_LOOPOFF] = loops_off_d && !loops_off_q;
  end

  // control output flops
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ssm_q <= 1'b1;
      nomtr_q <= 1'b0;
      bemf_fault_q <= 1'b0;
      flux_q <= `PCR_FLUX_P0;
      loops_off_q <= 1'b0;
      ccw_q <= 1'b0;
      dir_pin_q <= 1'b0;
      dir_stop_q <= 1'b0;
      dir_rev_q <= 1'b0;
    end
    else
    begin
      ssm_q <= ssm_d;
      nomtr_q <= nomtr_d;
      bemf_fault_q <= bemf_fault;
      flux_q <= flux_d;
      loops_off_q <= loops_off_d;
      ccw_q <= ccw_d;
      dir_pin_q <= dir_pin_i;
      dir_stop_q <= dir_stop_d;
      dir_rev_q <= dir_rev_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata_o = rdata_q;
  assign spread_clock_modulation_o = ssm_q;
  assign absent_motor_fault_o = nomtr_q;
  assign backemf_fault_o = bemf_fault_q;
  assign flux_weak_ref_o = flux_q;
  assign loops_off_o = loops_off_q;
  assign power_cmd_o = pwr_cap.cmd;
  assign power_capped_o = pwr_cap.capped;
  assign speed_cmd_o = spd_cap.cmd;
  assign speed_capped_o = spd_cap.capped;
  assign phase_order_ccw_o = ccw_q;
  assign dir_stop_isd_o = dir_stop_q;
  assign dir_reverse_drive_o = dir_rev_q;
  assign irq_o = irq_q;

endmodule

`default_nettype wire

/* File: tb/pcr_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

`include "pcr_cfg.svh"

module pcr_top_asserts #(
  parameter int W = 16,
  parameter int MS_CYCLES = 10
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [`PCR_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic dir_pin_i,
  input wire logic second_lock_detect_enable_i,
  input wire logic closed_loop_i,
  input wire logic no_motor_detect_i,
  input wire logic bemf_abnormal_i,
  input wire logic elec_cycle_i,
  input wire logic [1:0] input_ref_mode_i,
  input wire logic [W-1:0] bus_power_i,
  input wire logic [W-1:0] max_power_i,
  input wire logic [W-1:0] speed_ref_i,
  input wire logic [W-1:0] max_speed_i,
  input wire logic [W-1:0] ctrl_output_i,
  input wire logic [W-1:0] ctrl_reference_i,
  input wire logic spread_clock_modulation_o,
  input wire logic absent_motor_fault_o,
  input wire logic backemf_fault_o,
  input wire logic [6:0] flux_weak_ref_o,
  input wire logic loops_off_o,
  input wire logic [W-1:0] power_cmd_o,
  input wire logic power_capped_o,
  input wire logic [W-1:0] speed_cmd_o,
  input wire logic speed_capped_o,
  input wire logic phase_order_ccw_o,
  input wire logic dir_stop_isd_o,
  input wire logic dir_reverse_drive_o,
  input wire logic irq_o
);
  // ********************
  // config mirror and first-cycle guard
  // ********************
  logic live_q;
  logic [31:0] cfg_q;

  // live_q masks the edge right after reset release
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      live_q <= 1'h0;
      cfg_q <= `PCR_CFG_RESET;
    end
    else
    begin
      live_q <= 1'h1;
      if (reg_wr_i && reg_addr_i == `PCR_ADDR_CFG)
        cfg_q <= reg_wdata_i & `PCR_CFG_WMASK;
    end
  end

  // ********************
  // properties
  // ********************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_pin_moved;
    $past(dir_pin_i) != $past(dir_pin_i, 2);
  endsequence

  sequence s_pin_followed;
    $past(cfg_q[20:19]) == 2'h0 || $past(cfg_q[20:19]) == 2'h3;
  endsequence

  a_rdata_idle: assert property (live_q && !$past(reg_rd_i) |-> reg_rdata_o == 32'h00000000)
    else $error("read data not zero outside read");
  a_cfg_readback: assert property (live_q && $past(reg_rd_i) &&
    $past(reg_addr_i) == `PCR_ADDR_CFG |-> reg_rdata_o == $past(cfg_q))
    else $error("config read back wrong");
  a_dither_level: assert property (live_q |-> spread_clock_modulation_o == !$past(cfg_q[30]))
    else $error("dither output wrong");
  a_absent_gate: assert property (live_q |-> absent_motor_fault_o ==
    $past(closed_loop_i && no_motor_detect_i && second_lock_detect_enable_i && !cfg_q[28]))
    else $error("absent motor fault wrong");
  a_flux_table: assert property (live_q |-> flux_weak_ref_o ==
    ($past(cfg_q[25]) ? ($past(cfg_q[24]) ? `PCR_FLUX_P3 : `PCR_FLUX_P2)
    : ($past(cfg_q[24]) ? `PCR_FLUX_P1 : `PCR_FLUX_P0)))
    else $error("flux reference wrong");
  a_power_cap: assert property (live_q |-> power_cmd_o ==
    (($past(cfg_q[21]) && $past(input_ref_mode_i) != 2'h1 && $past(bus_power_i) >
    $past(max_power_i)) ? $past(max_power_i) : $past(bus_power_i)))
    else $error("power command wrong");
  a_speed_cap: assert property (live_q |-> speed_cmd_o ==
    (($past(cfg_q[17]) && $past(input_ref_mode_i) != 2'h0 && $past(speed_ref_i) >
    $past(max_speed_i)) ? $past(max_speed_i) : $past(speed_ref_i)))
    else $error("speed command wrong");
  a_dir_resolve: assert property (live_q |-> phase_order_ccw_o ==
    ($past(cfg_q[20:19]) == 2'h1 ? 1'h0 : $past(cfg_q[20:19]) == 2'h2 ? 1'h1 : $past(dir_pin_i)))
    else $error("direction wrong");
  a_dir_pulse: assert property (live_q && $past(live_q) ##0 s_pin_moved ##0 s_pin_followed
    |-> dir_stop_isd_o == !$past(cfg_q[18]) && dir_reverse_drive_o == $past(cfg_q[18]))
    else $error("direction change response wrong");
  a_dir_refuse: assert property (live_q && $past(live_q) &&
    (dir_stop_isd_o || dir_reverse_drive_o) |-> s_pin_moved ##0 s_pin_followed)
    else $error("direction pulse without cause");
  a_bemf_clear: assert property (live_q && $past(live_q) && !$past(bemf_abnormal_i) &&
    !$past(bemf_abnormal_i, 2) |-> !backemf_fault_o)
    else $error("back-emf fault outlives condition");
endmodule

bind pcr_top pcr_top_asserts #(.W(W), .MS_CYCLES(MS_CYCLES)) i_asserts (
  .mclk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .dir_pin_i, .second_lock_detect_enable_i, .closed_loop_i, .no_motor_detect_i,
  .bemf_abnormal_i, .elec_cycle_i, .input_ref_mode_i, .bus_power_i, .max_power_i,
  .speed_ref_i, .max_speed_i, .ctrl_output_i, .ctrl_reference_i, .spread_clock_modulation_o,
  .absent_motor_fault_o, .backemf_fault_o, .flux_weak_ref_o, .loops_off_o, .power_cmd_o,
  .power_capped_o, .speed_cmd_o, .speed_capped_o, .phase_order_ccw_o, .dir_stop_isd_o,
  .dir_reverse_drive_o, .irq_o
);

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

`include "pcr_cfg.svh"

module tb_top;
  localparam int W = 16;
  localparam int MS = 10;
  localparam logic [6:0] FLUX [4] = '{7'h46, 7'h50, 7'h5A, 7'h5F};
  localparam int TICKS [4] = '{0, 500, 1000, 2000};
  logic mclk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h00000000;
  logic reg_wr_i = 1'h0;
  logic reg_rd_i = 1'h0;
  logic dir_pin_i = 1'h0;
  logic second_lock_detect_enable_i = 1'h0;
  logic closed_loop_i = 1'h0;
  logic no_motor_detect_i = 1'h0;
  logic bemf_abnormal_i = 1'h0;
  logic elec_cycle_i = 1'h0;
  logic [1:0] input_ref_mode_i = 2'h0;
  logic [W-1:0] bus_power_i = 16'h01F4;
  logic [W-1:0] max_power_i = 16'h012C;
  logic [W-1:0] speed_ref_i = 16'h01F4;
  logic [W-1:0] max_speed_i = 16'h012C;
  logic [W-1:0] ctrl_output_i = 16'h0000;
  logic [W-1:0] ctrl_reference_i = 16'h0064;
  logic [31:0] reg_rdata_o;
  logic spread_clock_modulation_o, absent_motor_fault_o, backemf_fault_o, loops_off_o;
  logic [6:0] flux_weak_ref_o;
  logic [W-1:0] power_cmd_o, speed_cmd_o;
  logic power_capped_o, speed_capped_o, phase_order_ccw_o;
  logic dir_stop_isd_o, dir_reverse_drive_o, irq_o;
  int failures = 0;
  int comparisons = 0;
  int n;
  int lo;
  logic [31:0] d;

  // 250 MHz clock
  always #2 mclk_i = ~mclk_i;

  pcr_top #(.W(W), .MS_CYCLES(MS)) i_dut (
    .mclk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .dir_pin_i, .second_lock_detect_enable_i, .closed_loop_i, .no_motor_detect_i,
    .bemf_abnormal_i, .elec_cycle_i, .input_ref_mode_i, .bus_power_i, .max_power_i,
    .speed_ref_i, .max_speed_i, .ctrl_output_i, .ctrl_reference_i, .spread_clock_modulation_o,
    .absent_motor_fault_o, .backemf_fault_o, .flux_weak_ref_o, .loops_off_o, .power_cmd_o,
    .power_capped_o, .speed_cmd_o, .speed_capped_o, .phase_order_ccw_o, .dir_stop_isd_o,
    .dir_reverse_drive_o, .irq_o
  );

  // ********************
  // checking and bus tasks
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge mclk_i);
    reg_wr_i <= 1'h0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'h0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic wcfg(input logic [31:0] v);
    wr(`PCR_ADDR_CFG, v);
    settle(1);
  endtask

  task automatic flip(input logic es, input logic er);
    @(posedge mclk_i);
    dir_pin_i <= ~dir_pin_i;
    settle(1);
    chk(dir_stop_isd_o, es);
    chk(dir_reverse_drive_o, er);
  endtask

  // ********************
  // main sequence
  // ********************
  initial
  begin
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'h1;
    rd(`PCR_ADDR_CFG);
    chk(d, `PCR_CFG_RESET);
    chk(spread_clock_modulation_o, 1'h1);
    rd(8'h3C);
    chk(d, 32'h00000000);
    wcfg(32'hFFFFFFFF);
    rd(`PCR_ADDR_CFG);
    chk(d, 32'hDFFFFFE0);
    chk(spread_clock_modulation_o, 1'h0);
    for (int i = 0; i < 4; i++)
    begin
      wcfg(32'(i) << 24);
      chk(flux_weak_ref_o, FLUX[i]);
    end
    // 5 percent off sits on the boundary, 11 percent only fits code 3
    for (int o = 0; o < 2; o++)
    begin
      @(posedge mclk_i);
      ctrl_output_i <= (o == 0) ? 16'h0069 : 16'h006F;
      for (int i = 0; i < 4; i++)
      begin
        wcfg(32'(i) << 22);
        chk(loops_off_o, (o == 0) ? (i != 0) : (i == 3));
      end
    end
    wcfg(32'h00220000);
    for (int m = 0; m < 4; m++)
    begin
      @(posedge mclk_i);
      input_ref_mode_i <= 2'(m);
      settle(1);
      chk(power_cmd_o, (m == 1) ? 16'h01F4 : 16'h012C);
      chk(power_capped_o, m != 1);
      chk(speed_cmd_o, (m == 0) ? 16'h01F4 : 16'h012C);
      chk(speed_capped_o, m != 0);
    end
    wcfg(32'h00000000);
    chk(power_cmd_o, 16'h01F4);
    chk(speed_cmd_o, 16'h01F4);
    for (int c = 0; c < 4; c++)
    begin
      wcfg(32'(c) << 19);
      for (int p = 0; p < 2; p++)
      begin
        @(posedge mclk_i);
        dir_pin_i <= p[0];
        settle(1);
        chk(phase_order_ccw_o, (c == 1) ? 1'h0 : (c == 2) ? 1'h1 : p[0]);
      end
    end
    // direction change, its status bit and the interrupt
    wcfg(32'h00000000);
    wr(`PCR_ADDR_MASK, 32'h00000004);
    wr(`PCR_ADDR_STAT, 32'h0000000F);
    settle(2);
    chk(irq_o, 1'h0);
    flip(1'h1, 1'h0);
    settle(1);
    chk(irq_o, 1'h1);
    rd(`PCR_ADDR_STAT);
    chk(d[2], 1'h1);
    wr(`PCR_ADDR_STAT, 32'h00000004);
    settle(2);
    chk(irq_o, 1'h0);
    wcfg(32'h00040000);
    flip(1'h0, 1'h1);
    wcfg(32'h000C0000);
    flip(1'h0, 1'h0);
    wcfg(32'h001C0000);
    flip(1'h0, 1'h1);
    wr(`PCR_ADDR_MASK, 32'h00000000);
    settle(2);
    chk(irq_o, 1'h0);
    @(posedge mclk_i);
    closed_loop_i <= 1'h1;
    no_motor_detect_i <= 1'h1;
    second_lock_detect_enable_i <= 1'h1;
    settle(1);
    chk(absent_motor_fault_o, 1'h1);
    wcfg(32'h10000000);
    chk(absent_motor_fault_o, 1'h0);
    wcfg(32'h00000000);
    chk(absent_motor_fault_o, 1'h1);
    @(posedge mclk_i);
    second_lock_detect_enable_i <= 1'h0;
    settle(1);
    chk(absent_motor_fault_o, 1'h0);
    // persistence time per code, bounded wait for the fault
    for (int c = 0; c < 4; c++)
    begin
      wcfg(32'(c) << 26);
      @(posedge mclk_i);
      bemf_abnormal_i <= 1'h1;
      n = 0;
      lo = (c == 0) ? 30 : TICKS[c] * MS;
      while (backemf_fault_o !== 1'h1)
      begin
        @(posedge mclk_i);
        elec_cycle_i <= (c == 0) && (n % 20 == 9);
        n++;
        #1;
        if (n > lo + 50)
        begin
          failures++;
          summarize();
        end
      end
      chk(n >= lo && n <= lo + 6, 1'h1);
      @(posedge mclk_i);
      bemf_abnormal_i <= 1'h0;
      elec_cycle_i <= 1'h0;
      settle(3);
      chk(backemf_fault_o, 1'h0);
    end
    rd(`PCR_ADDR_STAT);
    chk(d, 32'h00000007);
    summarize();
  end
endmodule

`default_nettype wire
